/* File: verilog/aftfr_pkg.sv */
// shared constants for the alarm and fast-trip flag register bank
package aftfr_pkg;

   // register bus geometry: one byte register per aligned 32-bit word
   localparam int AFTFR_IDX_W = 9;
   localparam int AFTFR_ADDR_W = 11;
   localparam int AFTFR_DATA_W = 32;
   localparam int AFTFR_MASK_BYTES = 4;

   // register indices, byte address is four times the index
   localparam logic [8:0] AFTFR_IDX_ALARM2 = 9'h071;
   localparam logic [8:0] AFTFR_IDX_RSVD = 9'h072;
   localparam logic [8:0] AFTFR_IDX_FTRIP = 9'h073;
   localparam logic [8:0] AFTFR_IDX_MASK_SEL = 9'h0DA;
   localparam logic [8:0] AFTFR_IDX_CTRL = 9'h0E0;
   localparam logic [8:0] AFTFR_IDX_MASK0_BASE = 9'h0F8;
   localparam logic [8:0] AFTFR_IDX_MASK1_BASE = 9'h1F8;

   // field positions in the second alarm byte
   localparam int AFTFR_AUX3_HI_BIT = 7;
   localparam int AFTFR_AUX3_LO_BIT = 6;
   localparam int AFTFR_IRQ_BIT = 0;
   localparam logic [7:0] AFTFR_ALARM2_FLAG_MASK = 8'hC0;

   // field positions in the fast-trip byte
   localparam int AFTFR_FT_W = 5;
   localparam int AFTFR_FT_BIAS_WARN_BIT = 4;
   localparam int AFTFR_FT_BIAS_ALARM_BIT = 3;
   localparam int AFTFR_FT_LOSS_BIT = 2;
   localparam int AFTFR_FT_TXP_LOW_BIT = 1;
   localparam int AFTFR_FT_TXP_HIGH_BIT = 0;

   // control and select fields
   localparam int AFTFR_SEL_BIT = 0;
   localparam int AFTFR_CTRL_LATCH_BIT = 0;

   // reset values
   localparam logic [4:0] AFTFR_FT_RESET = 5'h00;
   localparam logic [7:0] AFTFR_MASK_RESET = 8'h00;
   localparam logic [7:0] AFTFR_READ_ZERO = 8'h00;

   // bus answer state
   typedef enum logic {AFTFR_IDLE, AFTFR_ANSWER} aftfr_bus_t;

   // byte address of a register index
   function automatic logic [10:0] aftfr_byte_addr(input logic [8:0] idx);
      return {idx, 2'b00};
   endfunction

endpackage

/* File: verilog/aftfr_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for asynchronous comparator levels
module aftfr_sync
   import aftfr_pkg::*;
#(
   parameter int W = AFTFR_FT_W
) (
   input wire logic clock, // system clock
   input wire logic rst, // asynchronous reset, high
   input wire logic [W-1:0] asyncIn, // levels from another domain
   output logic [W-1:0] syncOut // levels safe to use
);

   logic [W-1:0] firstStage;

   // first stage feeds only the second stage
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         firstStage <= '0;
         syncOut <= '0;
      end else begin
         firstStage <= asyncIn;
         syncOut <= firstStage;
      end
   end

endmodule // aftfr_sync

/* File: verilog/aftfr_irq_combine.sv */
`timescale 1ns/1ps
// masked or-reduction of alarm and warning flags
module aftfr_irq_combine
   import aftfr_pkg::*;
(
   input wire logic [31:0] flagBytes, // alarm and warning flag bytes
   input wire logic [31:0] maskBank0, // masks of bank zero
   input wire logic [31:0] maskBank1, // masks of bank one
   input wire logic maskSel, // bank choice
   output logic irqOut // any enabled flag set
);

   logic [31:0] activeMask;

   // choose bank, then and each flag with its enable and or them together
   always_comb begin
      activeMask = maskSel ? maskBank1 : maskBank0;
      irqOut = |(flagBytes & activeMask);
   end

endmodule // aftfr_irq_combine

/* File: verilog/aftfr_flag_regs.sv */
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module aftfr_flag_regs
   import aftfr_pkg::*;
(
   input wire logic clock, // system clock, 100 MHz
   input wire logic rst, // asynchronous reset, high
   input wire logic [10:0] address, // avalon byte address
   input wire logic read, // avalon read request
   input wire logic write, // avalon write request
   input wire logic [31:0] writedata, // avalon write data
   input wire logic [3:0] byteenable, // avalon byte lanes
   output logic [31:0] readdata, // avalon read data
   output logic waitrequest, // avalon stall
   input wire logic aux3ConvDone, // aux input three conversion finished
   input wire logic aux3AboveHigh, // conversion above high limit
   input wire logic aux3BelowLow, // conversion below low limit
   input wire logic [7:0] alarmFlagsFirst, // first alarm byte flags
   input wire logic [7:0] warnFlagsFirst, // first warning byte flags
   input wire logic [7:0] warnFlagsSecond, // second warning byte flags
   input wire logic biasWarnCmp, // bias warning comparator, async
   input wire logic biasAlarmCmp, // bias alarm comparator, async
   input wire logic signalLossCmp, // loss of signal comparator, async
   input wire logic txPowerLowCmp, // low tx power comparator, async
   input wire logic txPowerHighCmp, // high tx power comparator, async
   output logic maskableIrqOut, // maskable interrupt level
   output logic [4:0] fastTripFlags // fast-trip flag byte, low bits
);

   // flag state
   logic aux3HighAlarm;
   logic aux3LowAlarm;
   logic [4:0] ftSync;
   logic [4:0] next_ftFlags;
   logic maskableIrqFlag;

   // configuration state
   logic [7:0] maskBank0 [0:3];
   logic [7:0] maskBank1 [0:3];
   logic maskSel;
   logic latchMode;

   // bus state
   aftfr_bus_t busState;
   logic accessReq;
   logic writeNow;
   logic lowLane;
   logic ftWriteNow;
   logic [7:0] readByte;
   logic [31:0] flagBytes;
   logic [31:0] maskFlat0;
   logic [31:0] maskFlat1;
   logic [31:0] selMaskFlat;
   logic readTaken;

   // bus handshake: one wait cycle, answer on the following edge
   assign accessReq = read | write;
   assign waitrequest = accessReq & (busState == AFTFR_IDLE);
   assign writeNow = write & (busState == AFTFR_ANSWER);
   assign lowLane = byteenable[0];
   assign readTaken = read & (busState == AFTFR_IDLE);
   assign ftWriteNow = writeNow & lowLane & (address == aftfr_byte_addr(AFTFR_IDX_FTRIP));

   // answer state follows each request for exactly one cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busState <= AFTFR_IDLE;
      end else begin
         case (busState)
            AFTFR_IDLE: begin
               if (accessReq) begin
                  busState <= AFTFR_ANSWER;
               end
            end
            AFTFR_ANSWER: begin
               busState <= AFTFR_IDLE;
            end
            default: begin
               busState <= AFTFR_IDLE;
            end
         endcase
      end
   end

   // aux3 alarm flags reload from every conversion result
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         aux3HighAlarm <= 1'b0;
         aux3LowAlarm <= 1'b0;
      end else if (aux3ConvDone) begin
         aux3HighAlarm <= aux3AboveHigh;
         aux3LowAlarm <= aux3BelowLow;
      end
   end

   // comparator outputs are asynchronous to this clock
   aftfr_sync #(
      .W(AFTFR_FT_W)
   ) u_ft_sync (
      .clock(clock),
      .rst(rst),
      .asyncIn({biasWarnCmp, biasAlarmCmp, signalLossCmp, txPowerLowCmp, txPowerHighCmp}),
      .syncOut(ftSync)
   );

   // fast-trip next value: transparent or latched with clear by zero write
   always_comb begin
      if (!latchMode) begin
         next_ftFlags = ftSync;
      end else if (ftWriteNow) begin
         // a comparator still asserted wins over the clearing write
         next_ftFlags = (fastTripFlags & writedata[4:0]) | ftSync;
      end else begin
         next_ftFlags = fastTripFlags | ftSync;
      end
   end

   // fast-trip flag byte, volatile, cleared at reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fastTripFlags <= AFTFR_FT_RESET;
      end else begin
         fastTripFlags <= next_ftFlags;
      end
   end

   // mask bytes of both banks
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < AFTFR_MASK_BYTES; i++) begin
            maskBank0[i] <= AFTFR_MASK_RESET;
            maskBank1[i] <= AFTFR_MASK_RESET;
         end
      end else if (writeNow && lowLane) begin
         for (int i = 0; i < AFTFR_MASK_BYTES; i++) begin
            if (address == aftfr_byte_addr(AFTFR_IDX_MASK0_BASE + 9'(i))) begin
               maskBank0[i] <= writedata[7:0];
            end else if (address == aftfr_byte_addr(AFTFR_IDX_MASK1_BASE + 9'(i))) begin
               maskBank1[i] <= writedata[7:0];
            end
         end
      end
   end

   // mask bank select and latch mode control
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         maskSel <= 1'b0;
         latchMode <= 1'b0;
      end else if (writeNow && lowLane) begin
         if (address == aftfr_byte_addr(AFTFR_IDX_MASK_SEL)) begin
            maskSel <= writedata[AFTFR_SEL_BIT];
         end else if (address == aftfr_byte_addr(AFTFR_IDX_CTRL)) begin
            latchMode <= writedata[AFTFR_CTRL_LATCH_BIT];
         end
      end
   end

   // flatten flags and masks in byte order 70h, 71h, 74h, 75h
   assign flagBytes = {warnFlagsSecond & AFTFR_ALARM2_FLAG_MASK,
                       warnFlagsFirst,
                       {aux3HighAlarm, aux3LowAlarm, 6'h00},
                       alarmFlagsFirst};
   assign maskFlat0 = {maskBank0[3], maskBank0[2], maskBank0[1], maskBank0[0]};
   assign maskFlat1 = {maskBank1[3], maskBank1[2], maskBank1[1], maskBank1[0]};
   assign selMaskFlat = maskSel ? maskFlat1 : maskFlat0;

   // masked interrupt combine
   aftfr_irq_combine u_irq (
      .flagBytes(flagBytes),
      .maskBank0(maskFlat0),
      .maskBank1(maskFlat1),
      .maskSel(maskSel),
      .irqOut(maskableIrqFlag)
   );

   // interrupt flag also leaves the block as a level
   assign maskableIrqOut = maskableIrqFlag;

   // read byte selection, unmapped and reserved read as zero
   always_comb begin
      readByte = AFTFR_READ_ZERO;
      if (address == aftfr_byte_addr(AFTFR_IDX_ALARM2)) begin
         readByte[AFTFR_AUX3_HI_BIT] = aux3HighAlarm;
         readByte[AFTFR_AUX3_LO_BIT] = aux3LowAlarm;
         readByte[AFTFR_IRQ_BIT] = maskableIrqFlag;
      end else if (address == aftfr_byte_addr(AFTFR_IDX_RSVD)) begin
         readByte = AFTFR_READ_ZERO;
      end else if (address == aftfr_byte_addr(AFTFR_IDX_FTRIP)) begin
         readByte = {3'b000, fastTripFlags};
      end else if (address == aftfr_byte_addr(AFTFR_IDX_MASK_SEL)) begin
         readByte[AFTFR_SEL_BIT] = maskSel;
      end else if (address == aftfr_byte_addr(AFTFR_IDX_CTRL)) begin
         readByte[AFTFR_CTRL_LATCH_BIT] = latchMode;
      end else begin
         for (int i = 0; i < AFTFR_MASK_BYTES; i++) begin
            if (address == aftfr_byte_addr(AFTFR_IDX_MASK0_BASE + 9'(i))) begin
               readByte = maskBank0[i];
            end
            if (address == aftfr_byte_addr(AFTFR_IDX_MASK1_BASE + 9'(i))) begin
               readByte = maskBank1[i];
            end
         end
      end
   end

   // read data captured in the wait cycle, stands through the answer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readdata <= 32'h00000000;
      end else if (readTaken) begin
         readdata <= {24'h000000, readByte};
      end
   end

   // selected masks all zero keep interrupt low
   a_irq_all_masked: assert property (
      @(posedge clock) disable iff (rst)
      (selMaskFlat == 32'h00000000) |-> !maskableIrqOut)
      else $error("interrupt set with all masks zero");

   // interrupt matches the masked flag or
   a_irq_masked_or: assert property (
      @(posedge clock) disable iff (rst)
      maskableIrqOut == |(flagBytes & selMaskFlat))
      else $error("interrupt differs from masked flags");

   // high alarm loads from conversion result
   a_aux3_high_load: assert property (
      @(posedge clock) disable iff (rst)
      aux3ConvDone |=> aux3HighAlarm == $past(aux3AboveHigh))
      else $error("aux3 high alarm not loaded");

   // low alarm loads from conversion result
   a_aux3_low_load: assert property (
      @(posedge clock) disable iff (rst)
      aux3ConvDone |=> aux3LowAlarm == $past(aux3BelowLow))
      else $error("aux3 low alarm not loaded");

   // alarm flags hold between conversions
   a_aux3_hold: assert property (
      @(posedge clock) disable iff (rst)
      !aux3ConvDone |=> $stable(aux3HighAlarm) && $stable(aux3LowAlarm))
      else $error("aux3 alarm changed without conversion");

   // transparent mode tracks comparators three edges later
   a_ft_follow: assert property (
      @(posedge clock) disable iff (rst)
      !latchMode |=> fastTripFlags == $past(ftSync))
      else $error("fast-trip flags not following comparators");

   // latched mode keeps flags until a zero write
   a_ft_latch_clear: assert property (
      @(posedge clock) disable iff (rst)
      latchMode |=> fastTripFlags ==
         (($past(fastTripFlags) & ($past(ftWriteNow) ? $past(writedata[4:0]) : 5'h1F))
          | $past(ftSync)))
      else $error("latched fast-trip flag wrong");

   // upper fast-trip bits and high byte lanes read zero
   a_read_zero_bits: assert property (
      @(posedge clock) disable iff (rst)
      (read && busState == AFTFR_IDLE && address == aftfr_byte_addr(AFTFR_IDX_FTRIP))
      |=> readdata[7:5] == 3'b000 && readdata[31:8] == 24'h000000)
      else $error("fast-trip reserved bits not zero");

   // every request answered after exactly one wait cycle
   a_wait_one: assert property (
      @(posedge clock) disable iff (rst)
      (accessReq && waitrequest) |=> !waitrequest)
      else $error("waitrequest held too long");

   // second alarm byte read carries both aux3 alarm flags
   a_alarm2_aux_bits: assert property (
      @(posedge clock) disable iff (rst)
      (readTaken && address == aftfr_byte_addr(AFTFR_IDX_ALARM2))
      |=> readdata[7:6] == {$past(aux3HighAlarm), $past(aux3LowAlarm)})
      else $error("aux3 alarm bits in read data wrong");

   // second alarm byte read carries the interrupt flag
   a_irq_read_bit: assert property (
      @(posedge clock) disable iff (rst)
      (readTaken && address == aftfr_byte_addr(AFTFR_IDX_ALARM2))
      |=> readdata[0] == $past(maskableIrqOut))
      else $error("interrupt bit in read data wrong");

   // reserved bits of the second alarm byte read zero
   a_alarm2_rsvd_zero: assert property (
      @(posedge clock) disable iff (rst)
      (readTaken && address == aftfr_byte_addr(AFTFR_IDX_ALARM2))
      |=> readdata[5:1] == 5'h00 && readdata[31:8] == 24'h000000)
      else $error("reserved alarm bits not zero");

   // reserved byte reads zero
   a_rsvd_read_zero: assert property (
      @(posedge clock) disable iff (rst)
      (readTaken && address == aftfr_byte_addr(AFTFR_IDX_RSVD))
      |=> readdata == 32'h00000000)
      else $error("reserved byte not zero");

   // fast-trip read returns the flag register
   a_ft_read_value: assert property (
      @(posedge clock) disable iff (rst)
      (readTaken && address == aftfr_byte_addr(AFTFR_IDX_FTRIP))
      |=> readdata[4:0] == $past(fastTripFlags))
      else $error("fast-trip read data wrong");

   // mask bank select loads from a low lane write
   a_mask_sel_load: assert property (
      @(posedge clock) disable iff (rst)
      (writeNow && lowLane && address == aftfr_byte_addr(AFTFR_IDX_MASK_SEL))
      |=> maskSel == $past(writedata[AFTFR_SEL_BIT]))
      else $error("mask select not loaded");

   // a comparator still high sets its latched flag
   a_ft_set_wins: assert property (
      @(posedge clock) disable iff (rst)
      (latchMode && ftSync != 5'h00)
      |=> (fastTripFlags & $past(ftSync)) == $past(ftSync))
      else $error("latched flag lost while comparator set");

   // latched flags never drop without a clearing write
   a_ft_no_drop: assert property (
      @(posedge clock) disable iff (rst)
      (latchMode && !ftWriteNow)
      |=> ($past(fastTripFlags) & ~fastTripFlags) == 5'h00)
      else $error("latched flag dropped without write");

   // answer state lasts one cycle
   a_answer_once: assert property (
      @(posedge clock) disable iff (rst)
      (busState == AFTFR_ANSWER) |=> (busState == AFTFR_IDLE))
      else $error("answer state held too long");

endmodule // aftfr_flag_regs

/* File: verif/aftfr_host_model.sv */
`timescale 1ns/1ps
// avalon host that reaches the flag registers
module aftfr_host_model
   import aftfr_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic waitrequest, // slave stall
   output logic [10:0] address, // byte address
   output logic read, // read request
   output logic write, // write request
   output logic [31:0] writedata, // write data
   output logic [3:0] byteenable // byte lanes
);
   // idle bus at time zero
   initial begin
      address = 11'h000;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      byteenable = 4'hF;
   end

   // one transfer, held until the stall drops at a rising edge
   task automatic xfer(input logic wr, input logic [8:0] idx, input logic [7:0] d,
      input logic be);
      logic w;
      @(posedge clock);
      address <= {idx, 2'b00};
      writedata <= {24'h000000, d}; // zero bits clear latched trips
      byteenable <= {3'h7, be};
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clock);
         w = waitrequest; // value before this edge's updates
      end while (w);
      read <= 1'b0;
      write <= 1'b0;
   endtask
endmodule // aftfr_host_model

/* File: verif/aftfr_flag_regs_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the alarm and fast-trip flag registers
module aftfr_flag_regs_tb
   import aftfr_pkg::*;
;
   logic clock, rst, aux3ConvDone, aux3AboveHigh, aux3BelowLow;
   logic [7:0] alarmFlagsFirst, warnFlagsFirst, warnFlagsSecond;
   logic biasWarnCmp, biasAlarmCmp, signalLossCmp, txPowerLowCmp, txPowerHighCmp;
   wire logic [10:0] address;
   wire logic read, write, waitrequest, maskableIrqOut;
   wire logic [31:0] writedata, readdata;
   wire logic [3:0] byteenable;
   wire logic [4:0] fastTripFlags;
   int errors = 0;
   int cmp_count = 0;
   logic [8:0] q[$];
   logic [31:0] seed = 32'hEFCF17B5;
   logic [7:0] m0[4], m1[4];
   logic sel, a3hi, a3lo;

   aftfr_flag_regs aftfr_flag_regs_i (.clock(clock), .rst(rst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .aux3ConvDone(aux3ConvDone),
      .aux3AboveHigh(aux3AboveHigh), .aux3BelowLow(aux3BelowLow),
      .alarmFlagsFirst(alarmFlagsFirst), .warnFlagsFirst(warnFlagsFirst),
      .warnFlagsSecond(warnFlagsSecond), .biasWarnCmp(biasWarnCmp),
      .biasAlarmCmp(biasAlarmCmp), .signalLossCmp(signalLossCmp),
      .txPowerLowCmp(txPowerLowCmp), .txPowerHighCmp(txPowerHighCmp),
      .maskableIrqOut(maskableIrqOut), .fastTripFlags(fastTripFlags));
   aftfr_host_model aftfr_host_model_i (.clock(clock), .waitrequest(waitrequest),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable));

   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // shift register random source
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction

   // masked or of flag bytes with the selected bank
   function automatic logic expIrq();
      logic [7:0] m[4];
      for (int k = 0; k < 4; k++) m[k] = sel ? m1[k] : m0[k];
      return |(alarmFlagsFirst & m[0]) | |({a3hi, a3lo, 6'h00} & m[1]) |
         |(warnFlagsFirst & m[2]) | |({warnFlagsSecond[7:6], 6'h00} & m[3]);
   endfunction

   // note the expected byte and interrupt, then read
   task automatic rd(input logic [8:0] idx, input logic [7:0] d);
      q.push_back({expIrq(), d});
      aftfr_host_model_i.xfer(1'b0, idx, 8'h00, 1'b1);
   endtask

   task automatic rd71();
      rd(9'h071, {a3hi, a3lo, 5'h00, expIrq()});
   endtask

   // write and track mask and select shadows
   task automatic wr(input logic [8:0] idx, input logic [7:0] d, input logic be = 1'b1);
      if (be && idx[7:2] == 6'h3E) begin
         if (idx[8]) m1[idx[1:0]] = d;
         else m0[idx[1:0]] = d;
      end
      if (be && idx == 9'h0DA) sel = d[0];
      aftfr_host_model_i.xfer(1'b1, idx, d, be);
   endtask

   // drive comparator levels and let the synchroniser settle
   task automatic setCmp(input logic [4:0] v);
      @(posedge clock);
      {biasWarnCmp, biasAlarmCmp, signalLossCmp, txPowerLowCmp, txPowerHighCmp} <= v;
      repeat (4) @(posedge clock);
   endtask

   // compare each read at the edge that completes it with the oldest note
   always @(posedge clock) begin
      logic [8:0] e;
      if (read && !waitrequest) begin
         e = q.pop_front();
         cmp_count++;
         if (readdata !== {24'h000000, e[7:0]} || maskableIrqOut !== e[8]) begin
            errors++;
            $display("mismatch at %0t: addr %h got %h irq %b want %h irq %b", $time,
               address, readdata, maskableIrqOut, e[7:0], e[8]);
         end
         if (address == 11'h1CC && fastTripFlags !== e[4:0]) begin
            errors++;
            $display("mismatch at %0t: trip port %h want %h", $time, fastTripFlags, e[4:0]);
         end
      end
   end

   task automatic wrap_up();
      $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      wrap_up();
   end

   // main sequence
   initial begin
      rst = 1'b1;
      {aux3ConvDone, aux3AboveHigh, aux3BelowLow, sel, a3hi, a3lo} = 6'h00;
      {alarmFlagsFirst, warnFlagsFirst, warnFlagsSecond} = 24'h000000;
      {biasWarnCmp, biasAlarmCmp, signalLossCmp, txPowerLowCmp, txPowerHighCmp} = 5'h00;
      for (int k = 0; k < 4; k++) {m0[k], m1[k]} = 16'h0000;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd(9'h073, 8'h00);
      rd71();
      rd(9'h072, 8'h00);
      rd(9'h0F0, 8'h00);
      $display("test reset done");
      // conversions with random flag bytes while all masks are zero
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         {aux3AboveHigh, aux3BelowLow} <= i[1:0];
         aux3ConvDone <= 1'b1;
         {alarmFlagsFirst, warnFlagsFirst, warnFlagsSecond} <= {rnd(), rnd(), rnd()};
         @(posedge clock);
         aux3ConvDone <= 1'b0;
         {a3hi, a3lo} = i[1:0];
         rd71();
      end
      wr(9'h071, 8'hFF);
      rd71();
      $display("test conversion done");
      // random masks in both banks and random bank choice
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         {alarmFlagsFirst, warnFlagsFirst, warnFlagsSecond} <= {rnd(), rnd(), rnd()};
         for (int j = 0; j < 4; j++) wr(9'h0F8 + j[8:0], rnd() & rnd());
         for (int j = 0; j < 4; j++) wr(9'h1F8 + j[8:0], rnd() & rnd());
         wr(9'h0DA, rnd());
         rd71();
         rd(9'h0DA, {7'h00, sel});
         rd(9'h0F8 + 9'(i % 4), m0[i % 4]);
         rd(9'h1F8 + 9'(3 - i % 4), m1[3 - i % 4]);
      end
      $display("test mask done");
      // transparent trips follow the comparators
      for (int i = 0; i < 8; i++) begin
         setCmp(5'(rnd()));
         rd(9'h073, {3'h0, biasWarnCmp, biasAlarmCmp, signalLossCmp, txPowerLowCmp,
            txPowerHighCmp});
      end
      setCmp(5'h1F);
      rd(9'h073, 8'h1F);
      $display("test transparent done");
      // latched trips hold until written to zero
      wr(9'h0E0, 8'h01);
      rd(9'h0E0, 8'h01);
      setCmp(5'h00);
      rd(9'h073, 8'h1F);
      wr(9'h073, 8'h00, 1'b0);
      rd(9'h073, 8'h1F);
      wr(9'h073, 8'h15);
      rd(9'h073, 8'h15);
      setCmp(5'h02);
      wr(9'h073, 8'h00);
      rd(9'h073, 8'h02);
      setCmp(5'h00);
      wr(9'h073, 8'hFF);
      rd(9'h073, 8'h02);
      wr(9'h073, 8'h00);
      rd(9'h073, 8'h00);
      $display("test latched done");
      // a reset in mid-run clears latched trips, masks and control
      setCmp(5'h09);
      setCmp(5'h00);
      rd(9'h073, 8'h09);
      @(posedge clock);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      {sel, a3hi, a3lo} = 3'h0;
      for (int k = 0; k < 4; k++) {m0[k], m1[k]} = 16'h0000;
      rd(9'h073, 8'h00);
      rd(9'h0E0, 8'h00);
      rd71();
      $display("test mid reset done");
      repeat (2) @(posedge clock);
      wrap_up();
   end
endmodule // aftfr_flag_regs_tb
